// [hw/swrc_regs.sv]
// Overview of operation
// - trim writable only when unlock equals 11
// - receiver select writable only when unlocked
// - select 0 low-power, 1 standard receiver
// - reserved read-only bits always read zero
// - calibration high and low bytes, reset zero
// - filter codes 00/01/10 give 8/16/32
// - code 11 adapts constant from edge spacing
// - reset gives constant 16, recovery disabled
// - clock select gives 80/40/20/10 MHz
// - clamp limits beyond five percent of nominal
`timescale 1ns/100ps
`default_nettype none
`include "swrc_map.svh"
module swrc_regs
  import swrc_pkg::*;
(
  input wire logic sys_clk, // internal oscillator clock
  input wire logic rstn, // async reset, active low
  input wire logic soft_reset, // soft reset request, same clock
  input wire logic spi_sclk, // serial clock from host
  input wire logic spi_cs_n, // chip select, active low
  input wire logic spi_mosi, // serial data from host
  output logic spi_miso, // serial data to host
  output logic spi_miso_oe_n, // miso enable, low while driving
  input wire logic [1:0] trim_unlock, // trim-unlock field
  input wire logic [15:0] cal_value, // calibration result
  input wire logic cal_valid, // calibration result strobe
  input wire logic [7:0] nominal_bit_time, // programmed bit time
  input wire logic [7:0] recovery_upper_limit, // programmed upper limit
  input wire logic [7:0] recovery_lower_limit, // programmed lower limit
  input wire logic [3:0] edge_spacing_bits, // falling-edge distance
  input wire logic edge_spacing_valid, // spacing strobe
  input wire logic [7:0] measured_bit_time, // recovered bit time
  input wire logic measured_valid, // measurement strobe
  output logic [6:0] clock_trim_value, // oscillator trim
  output logic wake_receiver_select, // 1 standard receiver
  output logic recovery_enable, // recovery loop on
  output logic [5:0] filter_constant, // active time constant
  output logic [6:0] recovery_clock_mhz, // recovery clock choice
  output swrc_limits_t limits_eff, // clamped detection range
  output logic [7:0] bit_time_used // bit time in use
);

  // ---------------- link side, on the serial clock ----------------

  logic [4:0] bit_cnt_q;
  logic [15:0] shift_q;
  swrc_frame_t frame_q;
  logic frame_tgl_q;
  logic [7:0] resp_q;
  logic miso_q;
  logic miso_oe_n_q;
  logic [7:0] rd_word_q;

  // bit counter restarts with every select; the clock is idle between frames
  // a frame cut short leaves the count below sixteen, so nothing is latched
  always_ff @(posedge spi_sclk or negedge rstn or posedge spi_cs_n) begin
    if (!rstn) begin
      bit_cnt_q <= 5'h00;
    end else if (spi_cs_n) begin
      bit_cnt_q <= 5'h00;
    end else if (bit_cnt_q != `SWRC_BIT_DONE) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // shift in lsb first; a complete frame is parked and announced by toggle
  always_ff @(posedge spi_sclk or negedge rstn) begin
    if (!rstn) begin
      shift_q <= 16'h0000;
      frame_q <= '0;
      frame_tgl_q <= 1'b0;
    end else begin
      shift_q <= {spi_mosi, shift_q[15:1]};
      if (!spi_cs_n && bit_cnt_q == `SWRC_BIT_LAST) begin
        frame_q <= {spi_mosi, shift_q[15:1]};
        frame_tgl_q <= ~frame_tgl_q;
      end
    end
  end

  // answer goes out on falling edges in the data byte; first byte is zero.
  // rd_word_q only changes well after a frame, so the host must leave a gap
  always_ff @(negedge spi_sclk or negedge rstn or posedge spi_cs_n) begin
    if (!rstn) begin
      resp_q <= 8'h00;
      miso_q <= 1'b0;
      miso_oe_n_q <= 1'b1;
    end else if (spi_cs_n) begin
      miso_q <= 1'b0;
      miso_oe_n_q <= 1'b1;
    end else begin
      miso_oe_n_q <= 1'b0;
      if (bit_cnt_q[4:3] == `SWRC_DATA_PHASE) begin
        if (bit_cnt_q[2:0] == `SWRC_DATA_FIRST) begin
          resp_q <= rd_word_q;
          miso_q <= rd_word_q[0];
        end else begin
          miso_q <= resp_q[bit_cnt_q[2:0]];
        end
      end else begin
        miso_q <= 1'b0;
      end
    end
  end

  // pin drivers come straight from the falling-edge flops
  assign spi_miso = miso_q;
  assign spi_miso_oe_n = miso_oe_n_q;

  // ---------------- device side, on the oscillator clock ----------------

  // unlock field is a same-clock input, so it needs no synchroniser
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;
  logic frame_ev;
  logic frame_ev_q;
  logic unlocked;

  // toggle crossing; the first stage feeds only the second
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      frame_ev_q <= 1'b0;
    end else begin
      tgl_s1_q <= frame_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      frame_ev_q <= frame_ev;
    end
  end

  // one oscillator cycle of event per toggle, however long the gap
  assign frame_ev = tgl_s2_q ^ tgl_s3_q;
  assign unlocked = (trim_unlock == `SWRC_UNLOCK_KEY);

  logic [6:0] trim_q;
  logic trim_rsvd_q;
  logic rx_sel_q;
  logic [4:0] opt_rsvd_q;
  logic [15:0] cal_q;
  logic [1:0] filt_q;
  logic en_q;
  logic [1:0] clksel_q;
  logic wr_ev;

  // frame_q is stable for the whole frame that follows the event
  assign wr_ev = frame_ev && frame_q.write;

  // preset split into trim field and reserved bit; a literal cannot be sliced
  localparam logic [7:0] TRIM_PRESET = `SWRC_TRIM_PRESET;
  localparam logic [6:0] TRIM_FIELD_RST = TRIM_PRESET[6:0];
  localparam logic TRIM_RSVD_RST = TRIM_PRESET[7];

  // trim register; reserved bit simply stores what the host writes
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      trim_q <= TRIM_FIELD_RST;
      trim_rsvd_q <= TRIM_RSVD_RST;
    end else if (soft_reset) begin
      trim_q <= TRIM_FIELD_RST;
      trim_rsvd_q <= TRIM_RSVD_RST;
    end else if (wr_ev && frame_q.addr == `SWRC_ADDR_TRIM) begin
      trim_rsvd_q <= frame_q.data[7];
      if (unlocked) begin
        trim_q <= frame_q.data[6:0];
      end
    end
  end

  // options register; receiver select defaults to the low-power path
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_sel_q <= 1'b0;
      opt_rsvd_q <= `SWRC_OPT_PRESET;
    end else if (soft_reset) begin
      rx_sel_q <= 1'b0;
      opt_rsvd_q <= `SWRC_OPT_PRESET;
    end else if (wr_ev && frame_q.addr == `SWRC_ADDR_OPT) begin
      opt_rsvd_q <= frame_q.data[4:0];
      if (unlocked) begin
        rx_sel_q <= frame_q.data[`SWRC_RXSEL_BIT];
      end
    end
  end

  // calibration result; read-only from the host side
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cal_q <= {`SWRC_CAL_RST, `SWRC_CAL_RST};
    end else if (soft_reset) begin
      cal_q <= {`SWRC_CAL_RST, `SWRC_CAL_RST};
    end else if (cal_valid) begin
      cal_q <= cal_value;
    end
  end

  // recovery control one and two
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      filt_q <= `SWRC_FILT_RST;
      en_q <= 1'b0;
      clksel_q <= `SWRC_CLKSEL_RST;
    end else if (soft_reset) begin
      filt_q <= `SWRC_FILT_RST;
      en_q <= 1'b0;
      clksel_q <= `SWRC_CLKSEL_RST;
    end else if (wr_ev && frame_q.addr == `SWRC_ADDR_CTRL1) begin
      filt_q <= frame_q.data[3:2];
      en_q <= frame_q.data[`SWRC_EN_BIT];
    end else if (wr_ev && frame_q.addr == `SWRC_ADDR_CTRL2) begin
      clksel_q <= frame_q.data[1:0];
    end
  end

  // read image, taken a cycle after the event so a write shows its result;
  // unmapped addresses answer zero
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_word_q <= 8'h00;
    end else if (frame_ev_q) begin
      case (frame_q.addr)
        `SWRC_ADDR_TRIM: rd_word_q <= {trim_rsvd_q, trim_q};
        `SWRC_ADDR_OPT: rd_word_q <= {rx_sel_q, 2'h0, opt_rsvd_q};
        `SWRC_ADDR_CAL_H: rd_word_q <= cal_q[15:8];
        `SWRC_ADDR_CAL_L: rd_word_q <= cal_q[7:0];
        `SWRC_ADDR_CTRL1: rd_word_q <= {4'h0, filt_q, 1'b0, en_q};
        `SWRC_ADDR_CTRL2: rd_word_q <= {6'h00, clksel_q};
        default: rd_word_q <= 8'h00;
      endcase
    end
  end

  // ---------------- recovery configuration outputs ----------------

  logic [5:0] filt_c_q;
  logic [6:0] clk_mhz_q;

  // time constant: fixed codes map directly; adaptive keeps the last band
  // when the spacing falls outside 2 to 10 bits
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      filt_c_q <= `SWRC_TC16;
    end else begin
      case (filt_q)
        `SWRC_FILT_FIX8: filt_c_q <= `SWRC_TC8;
        `SWRC_FILT_FIX16: filt_c_q <= `SWRC_TC16;
        `SWRC_FILT_FIX32: filt_c_q <= `SWRC_TC32;
        default: begin
          if (edge_spacing_valid) begin
            if (edge_spacing_bits >= `SWRC_SPACE_2 && edge_spacing_bits <= `SWRC_SPACE_3) begin
              filt_c_q <= `SWRC_TC32;
            end else if (edge_spacing_bits >= `SWRC_SPACE_4 &&
                         edge_spacing_bits <= `SWRC_SPACE_8) begin
              filt_c_q <= `SWRC_TC16;
            end else if (edge_spacing_bits >= `SWRC_SPACE_9 &&
                         edge_spacing_bits <= `SWRC_SPACE_10) begin
              filt_c_q <= `SWRC_TC8;
            end
          end
        end
      endcase
    end
  end

  // recovery clock frequency choice
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clk_mhz_q <= `SWRC_CLK_80;
    end else begin
      case (clksel_q)
        2'h0: clk_mhz_q <= `SWRC_CLK_80;
        2'h1: clk_mhz_q <= `SWRC_CLK_40;
        2'h2: clk_mhz_q <= `SWRC_CLK_20;
        default: clk_mhz_q <= `SWRC_CLK_10;
      endcase
    end
  end

  // five percent bounds around nominal, truncated toward nominal
  logic [7:0] margin;
  logic [8:0] hi_bound;
  logic [7:0] lo_bound;
  logic [7:0] upper_c;
  logic [7:0] lower_c;

  assign margin = nominal_bit_time / `SWRC_MARGIN_DIV;
  assign hi_bound = {1'b0, nominal_bit_time} + {1'b0, margin};
  assign lo_bound = nominal_bit_time - margin;
  // an upper bound past the byte range can never be exceeded
  assign upper_c = ({1'b0, recovery_upper_limit} > hi_bound) ? hi_bound[7:0] :
                   recovery_upper_limit;
  assign lower_c = (recovery_lower_limit < lo_bound) ? lo_bound :
                   recovery_lower_limit;

  swrc_limits_t lim_q;
  logic [7:0] bt_q;

  // limits lag the inputs by one cycle so that they leave as flops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lim_q <= '0;
    end else begin
      lim_q <= '{upper: upper_c, lower: lower_c};
    end
  end

  // tracked bit time stays inside the clamped range; disabled means nominal
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bt_q <= 8'h00;
    end else if (!en_q) begin
      bt_q <= nominal_bit_time;
    end else if (measured_valid) begin
      if (measured_bit_time > upper_c) begin
        bt_q <= upper_c;
      end else if (measured_bit_time < lower_c) begin
        bt_q <= lower_c;
      end else begin
        bt_q <= measured_bit_time;
      end
    end
  end

  // every output is a register; these lines only rename
  assign clock_trim_value = trim_q;
  assign wake_receiver_select = rx_sel_q;
  assign recovery_enable = en_q;
  assign filter_constant = filt_c_q;
  assign recovery_clock_mhz = clk_mhz_q;
  assign limits_eff = lim_q;
  assign bit_time_used = bt_q;

endmodule
`default_nettype wire

// [shared/swrc_map.svh]
`ifndef SWRC_MAP_SVH
`define SWRC_MAP_SVH
// register addresses on the serial interface (7-bit)
`define SWRC_ADDR_TRIM 7'h38
`define SWRC_ADDR_OPT 7'h39
`define SWRC_ADDR_CAL_H 7'h3a
`define SWRC_ADDR_CAL_L 7'h3b
`define SWRC_ADDR_CTRL1 7'h3c
`define SWRC_ADDR_CTRL2 7'h3d
// unlock key for trim and receiver select
`define SWRC_UNLOCK_KEY 2'h3
// preset of reserved writable bits and trim; the value is arbitrary
`define SWRC_TRIM_PRESET 8'h40
`define SWRC_OPT_PRESET 5'h00
// field reset values
`define SWRC_FILT_RST 2'h1
`define SWRC_CLKSEL_RST 2'h0
`define SWRC_CAL_RST 8'h00
// field positions
`define SWRC_RXSEL_BIT 7
`define SWRC_EN_BIT 0
// filter time-constant codes and values
`define SWRC_FILT_FIX8 2'h0
`define SWRC_FILT_FIX16 2'h1
`define SWRC_FILT_FIX32 2'h2
`define SWRC_FILT_ADAPT 2'h3
`define SWRC_TC8 6'h08
`define SWRC_TC16 6'h10
`define SWRC_TC32 6'h20
// falling-edge spacing bands, in bits
`define SWRC_SPACE_2 4'h2
`define SWRC_SPACE_3 4'h3
`define SWRC_SPACE_4 4'h4
`define SWRC_SPACE_8 4'h8
`define SWRC_SPACE_9 4'h9
`define SWRC_SPACE_10 4'ha
// recovery clock frequencies in MHz
`define SWRC_CLK_80 7'h50
`define SWRC_CLK_40 7'h28
`define SWRC_CLK_20 7'h14
`define SWRC_CLK_10 7'h0a
// recovery limit margin: 5 percent is one twentieth
`define SWRC_MARGIN_DIV 8'h14
`define SWRC_BOUND_MAX 9'h0ff
// serial frame timing in bit counts
`define SWRC_BIT_LAST 5'h0f
`define SWRC_BIT_DONE 5'h10
`define SWRC_DATA_PHASE 2'h1
`define SWRC_DATA_FIRST 3'h0
`endif

// [shared/swrc_pkg.sv]
package swrc_pkg;
  // one serial frame, first received bit lands in addr[0]
  typedef struct packed {
    logic [7:0] data;
    logic write;
    logic [6:0] addr;
  } swrc_frame_t;
  // recovery detection range after clamping
  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
  } swrc_limits_t;
endpackage

// [test/swrc_host.sv]
`timescale 1ns/100ps
`default_nettype none
module swrc_host
  import swrc_pkg::*;
(
  output logic sclk, // still between frames
  output logic cs_n, // select, active low
  output logic mosi, // data to device
  input wire logic miso, // data from device
  input wire logic miso_oe_n // low while driven
);
  // idle: deselected, clock low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
  end
  // one frame lsb first; answer byte arrives in bits 8-15
  task automatic xfer(input swrc_frame_t f, output logic [7:0] rd);
    cs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      mosi = f[i];
      #16 sclk = 1'b1;
      if (i > 7)
        rd[i-8] = miso_oe_n ? 1'bx : miso;
      #16 sclk = 1'b0;
    end
    #16 cs_n = 1'b1;
    mosi = ~mosi; // released line does not keep the last bit
    #700; // gap covers the crossing and the read image
  endtask
endmodule
`default_nettype wire

// [test/swrc_regs_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module swrc_regs_monitor
  import swrc_pkg::*;
(
  input wire logic sys_clk, // oscillator clock
  input wire logic rstn, // reset, active low
  input wire logic soft_reset, // soft reset
  input wire logic [1:0] trim_unlock, // unlock field
  input wire logic [7:0] nominal_bit_time, // nominal
  input wire logic [7:0] recovery_upper_limit, // upper limit
  input wire logic [7:0] recovery_lower_limit, // lower limit
  input wire logic measured_valid, // measurement strobe
  input wire logic [6:0] clock_trim_value, // trim
  input wire logic wake_receiver_select, // receiver select
  input wire logic recovery_enable, // recovery on
  input wire logic [5:0] filter_constant, // time constant
  input wire logic [6:0] recovery_clock_mhz, // clock choice
  input wire swrc_limits_t limits_eff, // clamped range
  input wire logic [7:0] bit_time_used // bit time in use
);
  // expected range; margin is a twentieth of nominal, a 9-bit cap never clamps
  logic [8:0] hi_cap;
  logic [7:0] lo_cap, exp_hi, exp_lo;
  assign hi_cap = {1'b0, nominal_bit_time} + {1'b0, nominal_bit_time / 8'h14};
  assign lo_cap = nominal_bit_time - nominal_bit_time / 8'h14;
  assign exp_hi = ({1'b0, recovery_upper_limit} > hi_cap) ? hi_cap[7:0] : recovery_upper_limit;
  assign exp_lo = (recovery_lower_limit < lo_cap) ? lo_cap : recovery_lower_limit;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  a_trim_locked: assert property (
    $changed(clock_trim_value) && $past(rstn) && !$past(soft_reset) |-> $past(trim_unlock) == 2'h3)
    else $error("trim changed while locked");
  a_rxsel_locked: assert property (
    $changed(wake_receiver_select) && $past(rstn) && !$past(soft_reset)
    |-> $past(trim_unlock) == 2'h3) else $error("receiver select changed while locked");
  a_filter_legal: assert property (
    filter_constant inside {6'h08, 6'h10, 6'h20}) else $error("illegal time constant");
  a_clock_legal: assert property (
    recovery_clock_mhz inside {7'h50, 7'h28, 7'h14, 7'h0a}) else $error("illegal clock");
  // the clock choice is decoded one cycle after its select has reset
  a_soft_defaults: assert property (
    soft_reset |=> !recovery_enable && !wake_receiver_select && clock_trim_value == 7'h40
    ##1 recovery_clock_mhz == 7'h50) else $error("soft reset values wrong");
  a_soft_filter: assert property (
    $fell(soft_reset) |=> filter_constant == 6'h10) else $error("soft reset constant wrong");
  a_clamp_upper: assert property (
    $past(rstn) |-> limits_eff.upper == $past(exp_hi)) else $error("upper limit wrong");
  a_clamp_lower: assert property (
    $past(rstn) |-> limits_eff.lower == $past(exp_lo)) else $error("lower limit wrong");
  a_track_off: assert property (
    $past(rstn) && !$past(recovery_enable) |-> bit_time_used == $past(nominal_bit_time))
    else $error("bit time not nominal while disabled");
  a_track_range: assert property (
    recovery_enable && $past(recovery_enable) && $past(measured_valid) && $stable(limits_eff)
    |-> bit_time_used >= limits_eff.lower && bit_time_used <= limits_eff.upper)
    else $error("tracked bit time outside range");
  c_soft: cover property (soft_reset);
  c_trim: cover property ($changed(clock_trim_value));
  c_track: cover property (recovery_enable && measured_valid);
endmodule
bind swrc_regs swrc_regs_monitor mon (.sys_clk, .rstn, .soft_reset, .trim_unlock,
  .nominal_bit_time, .recovery_upper_limit, .recovery_lower_limit, .measured_valid,
  .clock_trim_value, .wake_receiver_select, .recovery_enable, .filter_constant,
  .recovery_clock_mhz, .limits_eff, .bit_time_used);
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "swrc_map.svh"
module testbench;
  import swrc_pkg::*;
  logic sys_clk, rstn, soft_reset, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
  logic cal_valid, edge_spacing_valid, measured_valid, wake_receiver_select, recovery_enable;
  logic [1:0] trim_unlock;
  logic [3:0] edge_spacing_bits;
  logic [5:0] filter_constant;
  logic [6:0] clock_trim_value, recovery_clock_mhz;
  logic [7:0] nominal_bit_time, recovery_upper_limit, recovery_lower_limit, measured_bit_time;
  logic [7:0] bit_time_used, v;
  logic [15:0] cal_value;
  swrc_limits_t limits_eff;
  int mismatches, check_count;
  swrc_regs DUT (.sys_clk, .rstn, .soft_reset, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso,
    .spi_miso_oe_n, .trim_unlock, .cal_value, .cal_valid, .nominal_bit_time,
    .recovery_upper_limit, .recovery_lower_limit, .edge_spacing_bits, .edge_spacing_valid,
    .measured_bit_time, .measured_valid, .clock_trim_value, .wake_receiver_select,
    .recovery_enable, .filter_constant, .recovery_clock_mhz, .limits_eff, .bit_time_used);
  swrc_host host (.sclk(spi_sclk), .cs_n(spi_cs_n), .mosi(spi_mosi), .miso(spi_miso),
    .miso_oe_n(spi_miso_oe_n));
  // 10 MHz oscillator clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({d, 1'b1, a}, v);
  endtask
  // answers are pipelined one frame, so a read takes two frames
  task automatic rdb(input logic [6:0] a);
    host.xfer({8'h00, 1'b0, a}, v);
    host.xfer({8'h00, 1'b0, a}, v);
  endtask
  task automatic results();
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_reset();
    chk("trim", 8'h40, {1'b0, clock_trim_value});
    chk("filter", 8'h10, {2'h0, filter_constant});
    chk("enable", 8'h00, {7'h00, recovery_enable});
    chk("rxsel", 8'h00, {7'h00, wake_receiver_select});
    rdb(`SWRC_ADDR_CTRL1);
    chk("ctrl1", 8'h04, v);
    rdb(`SWRC_ADDR_CAL_L);
    chk("cal_l", 8'h00, v);
  endtask
  // locked writes are dropped, unlocked ones taken; reserved bits stay at preset
  task automatic t_lock();
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk) trim_unlock <= k ? 2'h3 : 2'h0;
      wr(`SWRC_ADDR_TRIM, 8'h15);
      wr(`SWRC_ADDR_OPT, 8'he0);
      chk("trim", k ? 8'h15 : 8'h40, {1'b0, clock_trim_value});
      chk("rxsel", 8'(k), {7'h00, wake_receiver_select});
      rdb(`SWRC_ADDR_OPT);
      chk("opt", k ? 8'h80 : 8'h00, v);
    end
    @(posedge sys_clk) trim_unlock <= 2'h0;
  endtask
  task automatic t_clk();
    logic [6:0] mhz[4] = '{7'h50, 7'h28, 7'h14, 7'h0a};
    for (int c = 0; c < 4; c++) begin
      wr(`SWRC_ADDR_CTRL2, 8'hfc | 8'(c));
      chk("mhz", {1'b0, mhz[c]}, {1'b0, recovery_clock_mhz});
      rdb(`SWRC_ADDR_CTRL2);
      chk("ctrl2", 8'(c), v);
    end
    wr(`SWRC_ADDR_CTRL2, 8'h00);
  endtask
  task automatic t_filt();
    logic [5:0] tc[3] = '{6'h08, 6'h10, 6'h20};
    // every step but the last moves the constant; spacing eleven is outside all bands and keeps it
    logic [3:0] sp[7] = '{4'h4, 4'h2, 4'h9, 4'h8, 4'h3, 4'ha, 4'hb};
    logic [5:0] ad[7] = '{6'h10, 6'h20, 6'h08, 6'h10, 6'h20, 6'h08, 6'h08};
    for (int c = 0; c < 3; c++) begin
      wr(`SWRC_ADDR_CTRL1, {4'hf, 2'(c), 2'h3});
      chk("filter", {2'h0, tc[c]}, {2'h0, filter_constant});
      rdb(`SWRC_ADDR_CTRL1);
      chk("ctrl1", {4'h0, 2'(c), 2'h1}, v);
    end
    wr(`SWRC_ADDR_CTRL1, 8'h0d);
    for (int i = 0; i < 7; i++) begin
      @(posedge sys_clk) edge_spacing_bits <= sp[i];
      edge_spacing_valid <= 1'b1;
      @(posedge sys_clk) edge_spacing_valid <= 1'b0;
      step(3);
      chk("adapt", {2'h0, ad[i]}, {2'h0, filter_constant});
    end
  endtask
  task automatic t_cal();
    @(posedge sys_clk) cal_value <= 16'ha55a;
    cal_valid <= 1'b1;
    @(posedge sys_clk) cal_valid <= 1'b0;
    wr(`SWRC_ADDR_CAL_H, 8'h33);
    rdb(`SWRC_ADDR_CAL_H);
    chk("cal_h", 8'ha5, v);
    rdb(`SWRC_ADDR_CAL_L);
    chk("cal_l", 8'h5a, v);
    rdb(7'h20);
    chk("unmapped", 8'h00, v);
  endtask
  task automatic lim(input logic [7:0] up, lo, eu, el);
    @(posedge sys_clk) recovery_upper_limit <= up;
    recovery_lower_limit <= lo;
    step(3);
    chk("upper", eu, limits_eff.upper);
    chk("lower", el, limits_eff.lower);
  endtask
  task automatic meas(input logic [7:0] m, e);
    @(posedge sys_clk) measured_bit_time <= m;
    measured_valid <= 1'b1;
    @(posedge sys_clk) measured_valid <= 1'b0;
    step(3);
    chk("bit_time", e, bit_time_used);
  endtask
  // nominal 0xa0 gives a margin of 8
  task automatic t_clamp();
    lim(8'hc0, 8'h80, 8'ha8, 8'h98);
    lim(8'ha4, 8'h9c, 8'ha4, 8'h9c);
    meas(8'hb0, 8'ha4);
    meas(8'h90, 8'h9c);
    meas(8'h9e, 8'h9e);
    wr(`SWRC_ADDR_CTRL1, 8'h04);
    chk("bit_time", 8'ha0, bit_time_used);
    lim(8'ha8, 8'h98, 8'ha8, 8'h98);
  endtask
  task automatic t_soft();
    wr(`SWRC_ADDR_CTRL1, 8'h0b);
    wr(`SWRC_ADDR_CTRL2, 8'h03);
    @(posedge sys_clk) soft_reset <= 1'b1;
    @(posedge sys_clk) soft_reset <= 1'b0;
    step(3);
    chk("filter", 8'h10, {2'h0, filter_constant});
    chk("enable", 8'h00, {7'h00, recovery_enable});
    chk("rxsel", 8'h00, {7'h00, wake_receiver_select});
    chk("trim", 8'h40, {1'b0, clock_trim_value});
    chk("mhz", 8'h50, {1'b0, recovery_clock_mhz});
  endtask
  // inputs settle at time zero; bit time and limits as recommended for 80 MHz
  initial begin
    rstn <= 1'b0; // scheduled so every async reset sees its edge at time zero
    {soft_reset, cal_valid, edge_spacing_valid, measured_valid} = 4'h0;
    {trim_unlock, edge_spacing_bits, cal_value, measured_bit_time} = 30'h0;
    nominal_bit_time = 8'ha0;
    recovery_upper_limit = 8'ha8;
    recovery_lower_limit = 8'h98;
    mismatches = 0;
    check_count = 0;
    step(3);
    rstn <= 1'b1;
    step(2);
    t_reset();
    t_lock();
    t_clk();
    t_filt();
    t_cal();
    t_clamp();
    t_soft();
    results();
  end
  // watchdog well past the expected run of about 63 us
  initial begin
    #300000;
    mismatches++;
    results();
  end
endmodule
`default_nettype wire
